// ### src/tosc_handler.sv
// Command handler for a three-output programmable supply, Wishbone slave.
// Assumes a classic Wishbone master on sys_clk and an asynchronous meter path.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
module tosc_handler
  import tosc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tosc_level_t [2:0] measIn,
  output tosc_level_t [2:0] levelSet,
  output logic outEnable
);
  function automatic logic [15:0] voltMaxOf(input logic [1:0] idx);
    voltMaxOf = (idx == 2'h0) ? VOLT_MAX_SIX : VOLT_MAX_HIGH;
  endfunction

  function automatic logic [15:0] currMaxOf(input logic [1:0] idx);
    currMaxOf = (idx == 2'h0) ? CURR_MAX_SIX : CURR_MAX_HIGH;
  endfunction

  function automatic logic [15:0] currDefOf(input logic [1:0] idx);
    currDefOf = (idx == 2'h0) ? CURR_DEF_SIX : CURR_DEF_HIGH;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] din,
                                             input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = be[b] ? din[8*b +: 8] : old[8*b +: 8];
    end
    mergeBytes = old;
  endfunction

  // Bus slave
  logic [31:0] argVolt;
  logic [31:0] argCurr;
  logic [31:0] resp0;
  logic [31:0] resp1;
  logic [1:0] sel;
  logic [2:0] couple;
  logic track;
  logic err;
  logic trigImm;
  logic armed;
  tosc_level_t [2:0] measMeta;
  tosc_level_t [2:0] measSync;
  tosc_level_t [2:0] measLast;
  tosc_level_t [2:0] meas;
  tosc_level_t [2:0] pend;
  tosc_status_t status;

  wire logic busReq = wb_cyc_i & wb_stb_i;
  wire logic busWr = busReq & wb_we_i & wb_ack_o;
  wire logic cmdGo = busWr & (wb_adr_i == REG_CMD) & wb_sel_i[0];
  wire logic stsWr = busWr & (wb_adr_i == REG_STATUS) & wb_sel_i[0];
  wire tosc_cmd_t cmd = tosc_cmd_t'(wb_dat_i);
  wire tosc_op_t op = tosc_op_t'(cmd.op);
  wire tosc_status_t stsIn = tosc_status_t'(wb_dat_i);

  assign status = '{rsvd: '0, armed: armed, trigImm: trigImm, err: err, couple: couple,
                    track: track, outOn: outEnable, sel: sel};

  wire logic [31:0] readMux =
    (wb_adr_i == REG_ARG_VOLT) ? argVolt :
    (wb_adr_i == REG_ARG_CURR) ? argCurr :
    (wb_adr_i == REG_STATUS) ? status :
    (wb_adr_i == REG_RESP0) ? resp0 :
    (wb_adr_i == REG_RESP1) ? resp1 : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      wb_dat_o <= readMux;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      argVolt <= 32'h0000_0000;
      argCurr <= 32'h0000_0000;
    end else if (busWr && wb_adr_i == REG_ARG_VOLT) begin
      argVolt <= mergeBytes(argVolt, wb_dat_i, wb_sel_i);
    end else if (busWr && wb_adr_i == REG_ARG_CURR) begin
      argCurr <= mergeBytes(argCurr, wb_dat_i, wb_sel_i);
    end
  end

  // Meter words are used only once two samples agree, so a torn capture never lands
  wire logic measSteady = (measSync == measLast);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      measMeta <= '0;
      measSync <= '0;
      measLast <= '0;
      meas <= '0;
    end else begin
      measMeta <= measIn;
      measSync <= measMeta;
      measLast <= measSync;
      if (measSteady) begin
        meas <= measSync;
      end
    end
  end

  // Target output: the named one for naming commands, else the selection
  wire logic opNamed = (op == OP_APPLY) | (op == OP_APPLY_Q) | (op == OP_MEAS_V_Q) |
                       (op == OP_MEAS_I_Q);
  wire logic [1:0] tgt = (opNamed && cmd.outId != OUTPUT_NONE) ? cmd.outId : sel;
  wire logic [1:0] tIdx = tgt - 2'h1;
  wire logic [15:0] vMaxT = voltMaxOf(tIdx);
  wire logic [15:0] iMaxT = currMaxOf(tIdx);
  wire logic [15:0] vVal = (cmd.key == KEY_MIN) ? LEVEL_ZERO :
                           (cmd.key == KEY_MAX) ? vMaxT :
                           (cmd.key == KEY_DEF) ? VOLT_DEF : argVolt[15:0];
  wire logic [15:0] iVal = (cmd.key == KEY_MIN) ? LEVEL_ZERO :
                           (cmd.key == KEY_MAX) ? iMaxT :
                           (cmd.key == KEY_DEF) ? currDefOf(tIdx) : argCurr[15:0];
  wire logic argHigh = (argVolt[31:16] != 16'h0000) | (argCurr[31:16] != 16'h0000);
  wire logic vBad = (cmd.key == KEY_VALUE) & ((argVolt[15:0] > vMaxT) | argHigh);
  wire logic iBad = (cmd.key == KEY_VALUE) & ((argCurr[15:0] > iMaxT) | argHigh);
  wire logic [2:0] tgtMask = 3'h1 << tIdx;
  wire logic [2:0] selMask = 3'h1 << (sel - 2'h1);
  wire logic [2:0] fireMask = couple | selMask;
  wire logic highPair = (tIdx != 2'h0) & track;
  wire logic [1:0] queryBoundKey =
    (cmd.key == KEY_MIN || cmd.key == KEY_MAX) ? cmd.key : KEY_VALUE;

  logic [2:0] wrImmV;
  logic [2:0] wrImmI;
  logic [2:0] wrTrgV;
  logic [2:0] wrTrgI;
  logic [2:0] fire;
  logic [15:0] vIn;
  logic softRst;
  logic badCmd;
  logic [1:0] next_sel;
  logic [2:0] next_couple;
  logic next_track;
  logic next_outOn;
  logic next_trigImm;
  logic next_armed;
  logic [31:0] next_resp0;
  logic [31:0] next_resp1;

  always_comb begin
    wrImmV = 3'h0;
    wrImmI = 3'h0;
    wrTrgV = 3'h0;
    wrTrgI = 3'h0;
    fire = 3'h0;
    vIn = vVal;
    softRst = 1'b0;
    badCmd = 1'b0;
    next_sel = sel;
    next_couple = couple;
    next_track = track;
    next_outOn = outEnable;
    next_trigImm = trigImm;
    next_armed = armed;
    next_resp0 = resp0;
    next_resp1 = resp1;
    if (cmdGo) begin
      unique case (op)
        OP_NOP: begin
        end
        OP_APPLY: begin
          if (cmd.outId == OUTPUT_NONE || cmd.nvals == 2'h3) begin
            badCmd = 1'b1;
          end else if ((cmd.nvals != 2'h0 && vBad) || (cmd.nvals == 2'h2 && iBad)) begin
            badCmd = 1'b1;
          end else begin
            next_sel = cmd.outId;
            if (cmd.nvals != 2'h0) begin
              wrImmV = highPair ? 3'h6 : tgtMask;
            end
            if (cmd.nvals == 2'h2) begin
              wrImmI = tgtMask;
            end
          end
        end
        OP_APPLY_Q: begin
          next_resp0 = {16'h0000, levelSet[tIdx].volt};
          next_resp1 = {16'h0000, levelSet[tIdx].curr};
        end
        OP_SEL: begin
          if (cmd.outId == OUTPUT_NONE) begin
            badCmd = 1'b1;
          end else begin
            next_sel = cmd.outId;
          end
        end
        OP_SEL_Q: next_resp0 = {30'h0000_0000, sel};
        OP_COUPLE: begin
          if (argVolt[2:1] == 2'h3 && track) begin
            badCmd = 1'b1;
          end else begin
            next_couple = argVolt[2:0];
          end
        end
        OP_COUPLE_Q: begin
          next_resp0 = {29'h0000_0000, couple};
          next_resp1 = (couple == 3'h0) ? COUPLE_NONE :
                       (couple == COUPLE_MASK_ALL) ? COUPLE_ALL : COUPLE_LIST;
        end
        OP_MEAS_V_Q: next_resp0 = {16'h0000, meas[tIdx].volt};
        OP_MEAS_I_Q: next_resp0 = {16'h0000, meas[tIdx].curr};
        OP_OUT: next_outOn = argVolt[0];
        OP_OUT_Q: next_resp0 = {31'h0000_0000, outEnable};
        OP_TRACK: begin
          if (argVolt[0] && couple[2:1] == 2'h3) begin
            badCmd = 1'b1;
          end else begin
            next_track = argVolt[0];
            if (argVolt[0] && !track) begin
              vIn = levelSet[1].volt;
              wrImmV = 3'h4;
            end
          end
        end
        OP_TRACK_Q: next_resp0 = {31'h0000_0000, track};
        OP_VOLT, OP_VOLT_TRG: begin
          if (vBad) begin
            badCmd = 1'b1;
          end else if (op == OP_VOLT) begin
            wrImmV = highPair ? 3'h6 : tgtMask;
          end else begin
            wrTrgV = tgtMask;
          end
        end
        OP_CURR, OP_CURR_TRG: begin
          if (iBad) begin
            badCmd = 1'b1;
          end else if (op == OP_CURR) begin
            wrImmI = tgtMask;
          end else begin
            wrTrgI = tgtMask;
          end
        end
        OP_VOLT_Q, OP_VOLT_TRG_Q: begin
          next_resp0 = (queryBoundKey == KEY_MIN) ? 32'h0000_0000 :
                       (queryBoundKey == KEY_MAX) ? {16'h0000, vMaxT} :
                       (op == OP_VOLT_Q) ? {16'h0000, levelSet[tIdx].volt} :
                       {16'h0000, pend[tIdx].volt};
        end
        OP_CURR_Q, OP_CURR_TRG_Q: begin
          next_resp0 = (queryBoundKey == KEY_MIN) ? 32'h0000_0000 :
                       (queryBoundKey == KEY_MAX) ? {16'h0000, iMaxT} :
                       (op == OP_CURR_Q) ? {16'h0000, levelSet[tIdx].curr} :
                       {16'h0000, pend[tIdx].curr};
        end
        OP_TRIG_SRC: next_trigImm = argVolt[0];
        OP_INIT: begin
          if (trigImm) begin
            fire = fireMask;
          end else begin
            next_armed = 1'b1;
          end
        end
        OP_TRG: begin
          if (armed) begin
            fire = fireMask;
            next_armed = 1'b0;
          end
        end
        OP_RST: begin
          softRst = 1'b1;
          next_sel = SIX_VOLT_OUTPUT_ID;
          next_couple = 3'h0;
          next_track = 1'b0;
          next_outOn = 1'b0;
          next_trigImm = 1'b0;
          next_armed = 1'b0;
        end
        default: badCmd = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel <= SIX_VOLT_OUTPUT_ID;
      couple <= 3'h0;
      track <= 1'b0;
      outEnable <= 1'b0;
      trigImm <= 1'b0;
      armed <= 1'b0;
      resp0 <= 32'h0000_0000;
      resp1 <= 32'h0000_0000;
      err <= 1'b0;
    end else begin
      sel <= next_sel;
      couple <= next_couple;
      track <= next_track;
      outEnable <= next_outOn;
      trigImm <= next_trigImm;
      armed <= next_armed;
      resp0 <= next_resp0;
      resp1 <= next_resp1;
      err <= badCmd | (err & ~(stsWr & stsIn.err));
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_ch
    tosc_channel #(.I_DEF(g == 0 ? CURR_DEF_SIX : CURR_DEF_HIGH)) u_ch (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .softRst(softRst),
      .wrImmV(wrImmV[g]),
      .wrImmI(wrImmI[g]),
      .wrTrgV(wrTrgV[g]),
      .wrTrgI(wrTrgI[g]),
      .fire(fire[g]),
      .vIn(vIn),
      .iIn(iVal),
      .level(levelSet[g]),
      .pending(pend[g])
    );
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_wb_ack;
    busReq && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle after request");

  property p_apply_sets;
    cmdGo && op == OP_APPLY && cmd.nvals == 2'h2 && cmd.key == KEY_VALUE && !vBad && !iBad &&
      cmd.outId != OUTPUT_NONE && !highPair
    |=> sel == $past(cmd.outId) && levelSet[$past(tIdx)].volt == $past(argVolt[15:0]) &&
        levelSet[$past(tIdx)].curr == $past(argCurr[15:0]);
  endproperty
  a_apply_sets: assert property (p_apply_sets)
    else $error("apply did not take effect");

  property p_max_key;
    cmdGo && op == OP_VOLT && cmd.key == KEY_MAX |=> levelSet[$past(tIdx)].volt == $past(vMaxT);
  endproperty
  a_max_key: assert property (p_max_key) else $error("max keyword not at bound");

  property p_soft_reset;
    softRst |=> levelSet[0].curr == CURR_DEF_SIX && levelSet[1].curr == CURR_DEF_HIGH &&
      levelSet[2].curr == CURR_DEF_HIGH && levelSet[2].volt == VOLT_DEF && !outEnable;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset levels wrong");

  property p_apply_select_only;
    cmdGo && op == OP_APPLY && cmd.nvals == 2'h0 && cmd.outId != OUTPUT_NONE
    |=> $stable(levelSet) && sel == $past(cmd.outId);
  endproperty
  a_apply_select_only: assert property (p_apply_select_only)
    else $error("bare apply changed levels");

  property p_sel_query;
    cmdGo && op == OP_SEL_Q |=> resp0 == {30'h0000_0000, $past(sel)};
  endproperty
  a_sel_query: assert property (p_sel_query) else $error("selection query wrong");

  property p_couple_track;
    couple[2:1] == 2'h3 |-> !track;
  endproperty
  a_couple_track: assert property (p_couple_track)
    else $error("high pair coupled while tracking");

  property p_track_on;
    $rose(track) |-> $past(couple[2:1]) != 2'h3 && levelSet[2].volt == levelSet[1].volt;
  endproperty
  a_track_on: assert property (p_track_on) else $error("track enable wrong");

  property p_track_mirror;
    track && cmdGo && op == OP_VOLT && sel == POSITIVE_HIGH_OUTPUT_ID && !vBad
    |=> levelSet[2].volt == levelSet[1].volt;
  endproperty
  a_track_mirror: assert property (p_track_mirror) else $error("track not mirrored");

  property p_out_state;
    cmdGo && op == OP_OUT |=> outEnable == $past(argVolt[0]);
  endproperty
  a_out_state: assert property (p_out_state) else $error("output state not set");

  property p_reject;
    cmdGo && op == OP_CURR && iBad |=> err && $stable(levelSet);
  endproperty
  a_reject: assert property (p_reject) else $error("bad value not rejected");

  property p_init_imm;
    cmdGo && op == OP_INIT && trigImm && couple[0] |=> levelSet[0] == $past(pend[0]);
  endproperty
  a_init_imm: assert property (p_init_imm)
    else $error("initiate did not load pending");

  c_apply: cover property (cmdGo && op == OP_APPLY && cmd.nvals == 2'h2);
  c_track: cover property ($rose(track));
  c_bus_trig: cover property (cmdGo && op == OP_TRG && armed);
  c_error: cover property ($rose(err));
endmodule

// ### src/tosc_pkg.sv
// Shared constants and types for the triple-output setting command handler.
// Assumes one 50 MHz clock; levels are unsigned magnitudes in mV and mA.
package tosc_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG_VOLT = 8'h04;
  localparam logic [7:0] REG_ARG_CURR = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RESP0 = 8'h10;
  localparam logic [7:0] REG_RESP1 = 8'h14;

  // Output identifiers, also the numeric selection values
  localparam logic [1:0] OUTPUT_NONE = 2'h0;
  localparam logic [1:0] SIX_VOLT_OUTPUT_ID = 2'h1;
  localparam logic [1:0] POSITIVE_HIGH_OUTPUT_ID = 2'h2;
  localparam logic [1:0] NEGATIVE_HIGH_OUTPUT_ID = 2'h3;

  // Parameter keywords
  localparam logic [1:0] KEY_VALUE = 2'h0;
  localparam logic [1:0] KEY_MIN = 2'h1;
  localparam logic [1:0] KEY_MAX = 2'h2;
  localparam logic [1:0] KEY_DEF = 2'h3;

  // Programmable bounds and defaults (mV, mA)
  localparam logic [15:0] LEVEL_ZERO = 16'h0000;
  localparam logic [15:0] VOLT_MAX_SIX = 16'h1824;   // 6180 mV
  localparam logic [15:0] VOLT_MAX_HIGH = 16'h6496;  // 25750 mV magnitude
  localparam logic [15:0] CURR_MAX_SIX = 16'h141E;   // 5150 mA
  localparam logic [15:0] CURR_MAX_HIGH = 16'h0406;  // 1030 mA
  localparam logic [15:0] VOLT_DEF = 16'h0000;
  localparam logic [15:0] CURR_DEF_SIX = 16'h1388;   // 5000 mA
  localparam logic [15:0] CURR_DEF_HIGH = 16'h03E8;  // 1000 mA

  // Coupling query answer codes
  localparam logic [31:0] COUPLE_NONE = 32'h0000_0000;
  localparam logic [31:0] COUPLE_ALL = 32'h0000_0001;
  localparam logic [31:0] COUPLE_LIST = 32'h0000_0002;
  localparam logic [2:0] COUPLE_MASK_ALL = 3'h7;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
  } tosc_level_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [1:0] nvals;
    logic [1:0] key;
    logic [1:0] outId;
    logic [4:0] op;
  } tosc_cmd_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic armed;
    logic trigImm;
    logic err;
    logic [2:0] couple;
    logic track;
    logic outOn;
    logic [1:0] sel;
  } tosc_status_t;

  typedef enum logic [4:0] {
    OP_NOP, OP_APPLY, OP_APPLY_Q, OP_SEL, OP_SEL_Q, OP_COUPLE, OP_COUPLE_Q,
    OP_MEAS_V_Q, OP_MEAS_I_Q, OP_OUT, OP_OUT_Q, OP_TRACK, OP_TRACK_Q,
    OP_VOLT, OP_VOLT_Q, OP_VOLT_TRG, OP_VOLT_TRG_Q, OP_CURR, OP_CURR_Q,
    OP_CURR_TRG, OP_CURR_TRG_Q, OP_TRIG_SRC, OP_INIT, OP_TRG, OP_RST
  } tosc_op_t;

endpackage

// ### src/tosc_channel.sv
// One output channel: immediate and pending triggered voltage/current levels.
// Assumes single-cycle write strobes from the command handler on sys_clk.
`timescale 1ns/10ps
module tosc_channel
  import tosc_pkg::*;
#(
  parameter logic [15:0] I_DEF = CURR_DEF_HIGH
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic softRst,
  input wire logic wrImmV,
  input wire logic wrImmI,
  input wire logic wrTrgV,
  input wire logic wrTrgI,
  input wire logic fire,
  input wire logic [15:0] vIn,
  input wire logic [15:0] iIn,
  output tosc_level_t level,
  output tosc_level_t pending
);
  tosc_level_t trg;
  logic trgVSet;
  logic trgISet;

  // Unprogrammed triggered levels read back as the immediate levels
  assign pending.volt = trgVSet ? trg.volt : level.volt;
  assign pending.curr = trgISet ? trg.curr : level.curr;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= '{volt: VOLT_DEF, curr: I_DEF};
    end else if (softRst) begin
      level <= '{volt: VOLT_DEF, curr: I_DEF};
    end else if (fire) begin
      level <= pending;
    end else begin
      if (wrImmV) begin
        level.volt <= vIn;
      end
      if (wrImmI) begin
        level.curr <= iIn;
      end
    end
  end

  // Stored triggered levels change only on their own writes and on soft reset; unset ones read back the immediate levels
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trg <= '{volt: VOLT_DEF, curr: I_DEF};
      trgVSet <= 1'b0;
      trgISet <= 1'b0;
    end else if (softRst) begin
      trg <= '{volt: VOLT_DEF, curr: I_DEF};
      trgVSet <= 1'b0;
      trgISet <= 1'b0;
    end else begin
      if (wrTrgV) begin
        trg.volt <= vIn;
        trgVSet <= 1'b1;
      end
      if (wrTrgI) begin
        trg.curr <= iIn;
        trgISet <= 1'b1;
      end
    end
  end
endmodule

// ### testbench/tosc_meter_model.sv
// Meter path model: reads back the programmed levels while outputs are on.
// Assumes ideal regulation; disabled outputs read zero.
`timescale 1ns/10ps
module tosc_meter_model
  import tosc_pkg::*;
(
  input wire tosc_level_t [2:0] levelSet,
  input wire logic outEnable,
  output tosc_level_t [2:0] measIn
);
  assign measIn = outEnable ? levelSet : '0;
endmodule

// ### testbench/tb_tosc_handler.sv
// Testbench for the command handler: Wishbone master and scenarios.
// Assumes the meter model closes the loop from levels to measurements.
`timescale 1ns/10ps
module tb_tosc_handler;
  import tosc_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] datW = 32'h0;
  logic [3:0] sel = 4'hF;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] datR;
  logic ack;
  logic outEn;
  tosc_level_t [2:0] lvl;
  tosc_level_t [2:0] meas;
  int errCount = 0;
  int checks = 0;
  logic [31:0] q;
  always #10 sys_clk = ~sys_clk;
  tosc_handler tosc_handler_i (.sys_clk(sys_clk), .arst_n(arst_n), .wb_adr_i(adr),
    .wb_dat_i(datW), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(datR), .wb_ack_o(ack), .measIn(meas), .levelSet(lvl), .outEnable(outEn));
  tosc_meter_model tosc_meter_model_i (.levelSet(lvl), .outEnable(outEn), .measIn(meas));
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic cmd(input logic [4:0] op, input logic [1:0] o, input logic [1:0] k,
      input logic [1:0] n);
    wb(1'b1, REG_CMD, {21'h0, n, k, o, op});
  endtask
  task automatic args(input logic [15:0] v, input logic [15:0] c);
    wb(1'b1, REG_ARG_VOLT, {16'h0, v});
    wb(1'b1, REG_ARG_CURR, {16'h0, c});
  endtask
  task automatic rq(input logic [4:0] op, input logic [1:0] o, input logic [7:0] a);
    cmd(op, o, KEY_VALUE, 2'h0);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errCount++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic t_reset;
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", q, 32'h0000_0001);
    chk("lvl0", lvl[0], {VOLT_DEF, CURR_DEF_SIX});
    chk("lvl2", lvl[2], {VOLT_DEF, CURR_DEF_HIGH});
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask
  task automatic t_apply;
    args(16'h0BB8, 16'h03E8);
    cmd(OP_APPLY, POSITIVE_HIGH_OUTPUT_ID, KEY_VALUE, 2'h2);
    chk("apply", lvl[1], 32'h0BB8_03E8);
    cmd(OP_APPLY, SIX_VOLT_OUTPUT_ID, KEY_MAX, 2'h2);
    chk("max", lvl[0], {VOLT_MAX_SIX, CURR_MAX_SIX});
    args(16'h04D2, 16'h0000);
    cmd(OP_APPLY, NEGATIVE_HIGH_OUTPUT_ID, KEY_VALUE, 2'h1);
    chk("onev", lvl[2], {16'h04D2, CURR_DEF_HIGH});
    rq(OP_APPLY_Q, OUTPUT_NONE, REG_RESP0);
    chk("aqv", q, 32'h04D2);
    wb(1'b0, REG_RESP1, 32'h0);
    chk("aqi", q, {16'h0, CURR_DEF_HIGH});
  endtask
  task automatic t_select;
    for (int k = 1; k <= 3; k++) begin
      cmd(OP_SEL, 2'(k), KEY_VALUE, 2'h0);
      rq(OP_SEL_Q, OUTPUT_NONE, REG_RESP0);
      chk("selq", q, 32'(k));
      args(16'h0BB8, 16'h0064 + 16'(k));
      cmd(OP_CURR, OUTPUT_NONE, KEY_VALUE, 2'h1);
      chk("curr", {16'h0, lvl[k-1].curr}, 32'h64 + 32'(k));
    end
    chk("keep", {16'h0, lvl[0].curr}, 32'h65);
  endtask
  task automatic t_range;
    args(16'h6497, 16'h0000);
    cmd(OP_VOLT, OUTPUT_NONE, KEY_VALUE, 2'h1);
    chk("range", lvl[2], 32'h04D2_0067);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("err", q & 32'h80, 32'h80);
    wb(1'b1, REG_STATUS, 32'h80);
    args(16'h0000, 16'h0407);
    cmd(OP_CURR, OUTPUT_NONE, KEY_VALUE, 2'h1);
    chk("irange", lvl[2], 32'h04D2_0067);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("ierr", q & 32'h80, 32'h80);
    wb(1'b1, REG_STATUS, 32'h80);
  endtask
  task automatic t_trig;
    cmd(OP_SEL, SIX_VOLT_OUTPUT_ID, KEY_VALUE, 2'h0);
    args(16'h01F4, 16'h07D0);
    cmd(OP_VOLT_TRG, OUTPUT_NONE, KEY_VALUE, 2'h1);
    cmd(OP_CURR_TRG, OUTPUT_NONE, KEY_VALUE, 2'h1);
    args(16'h0001, 16'h012C);
    cmd(OP_CURR, OUTPUT_NONE, KEY_VALUE, 2'h1);
    chk("imm", lvl[0], {VOLT_MAX_SIX, 16'h012C});
    cmd(OP_COUPLE, OUTPUT_NONE, KEY_VALUE, 2'h1);
    rq(OP_COUPLE_Q, OUTPUT_NONE, REG_RESP1);
    chk("coupq", q, COUPLE_LIST);
    cmd(OP_TRIG_SRC, OUTPUT_NONE, KEY_VALUE, 2'h1);
    cmd(OP_INIT, OUTPUT_NONE, KEY_VALUE, 2'h0);
    chk("trig", lvl[0], 32'h01F4_07D0);
  endtask
  task automatic t_track;
    cmd(OP_OUT, OUTPUT_NONE, KEY_VALUE, 2'h1);
    chk("outen", {31'h0, outEn}, 32'h1);
    cmd(OP_TRACK, OUTPUT_NONE, KEY_VALUE, 2'h1);
    chk("copy", {16'h0, lvl[2].volt}, 32'h0BB8);
    cmd(OP_SEL, POSITIVE_HIGH_OUTPUT_ID, KEY_VALUE, 2'h0);
    args(16'h1B58, 16'h0000);
    cmd(OP_VOLT, OUTPUT_NONE, KEY_VALUE, 2'h1);
    chk("mirror", {16'h0, lvl[2].volt}, 32'h1B58);
    repeat (4) @(posedge sys_clk);
    rq(OP_MEAS_V_Q, NEGATIVE_HIGH_OUTPUT_ID, REG_RESP0);
    chk("meas", q, 32'h1B58);
    args(16'h0006, 16'h0000);
    cmd(OP_COUPLE, OUTPUT_NONE, KEY_VALUE, 2'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("cpltrk", q & 32'hF0, 32'h90);
  endtask
  task automatic t_bus;
    wb(1'b1, REG_STATUS, 32'h80);
    args(16'h0000, 16'h0000);
    cmd(OP_TRACK, OUTPUT_NONE, KEY_VALUE, 2'h1);
    args(16'h0006, 16'h0000);
    cmd(OP_COUPLE, OUTPUT_NONE, KEY_VALUE, 2'h1);
    args(16'h0001, 16'h0000);
    cmd(OP_TRACK, OUTPUT_NONE, KEY_VALUE, 2'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("trkcpl", q & 32'hF8, 32'hE0);
    rq(OP_CURR_TRG_Q, OUTPUT_NONE, REG_RESP0);
    chk("trgq", q, 32'h0066);
    cmd(OP_CURR_Q, OUTPUT_NONE, KEY_MAX, 2'h0);
    wb(1'b0, REG_RESP0, 32'h0);
    chk("imax", q, {16'h0, CURR_MAX_HIGH});
    args(16'h0000, 16'h0000);
    cmd(OP_TRIG_SRC, OUTPUT_NONE, KEY_VALUE, 2'h1);
    args(16'h2710, 16'h01F4);
    cmd(OP_VOLT_TRG, OUTPUT_NONE, KEY_VALUE, 2'h1);
    cmd(OP_CURR_TRG, OUTPUT_NONE, KEY_VALUE, 2'h1);
    cmd(OP_INIT, OUTPUT_NONE, KEY_VALUE, 2'h0);
    chk("armed", lvl[1], 32'h1B58_0066);
    cmd(OP_TRG, OUTPUT_NONE, KEY_VALUE, 2'h0);
    chk("bustrg", lvl[1], 32'h2710_01F4);
    chk("pend2", lvl[2], 32'h1B58_0067);
    cmd(OP_VOLT, OUTPUT_NONE, KEY_MAX, 2'h1);
    chk("vmax", {16'h0, lvl[1].volt}, {16'h0, VOLT_MAX_HIGH});
    cmd(OP_APPLY, SIX_VOLT_OUTPUT_ID, KEY_VALUE, 2'h0);
    rq(OP_SEL_Q, OUTPUT_NONE, REG_RESP0);
    chk("selonly", q, 32'h1);
    chk("keep0", lvl[0], 32'h01F4_07D0);
    wb(1'b1, REG_STATUS, 32'h80);
    cmd(OP_RST, OUTPUT_NONE, KEY_VALUE, 2'h0);
    t_reset();
  endtask
  task automatic end_sim;
    if (errCount == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_apply();
    t_select();
    t_range();
    t_trig();
    t_track();
    t_bus();
    end_sim();
  end
  initial begin
    #200000;
    errCount++;
    end_sim();
  end
endmodule
